// >>> src/cpm_pkg.sv
// package for the control pin and supply mode logic of the switch
// assumes eight channels and two direct input pins
package cpm_pkg;

	// ---------------------------------------------------------------
	// channel layout
	// ---------------------------------------------------------------
	localparam int CPM_CHANNELS = 8;
	localparam int CPM_INPUTS = 2;
	localparam int CPM_DEFAULT_CH_A = 2;
	localparam int CPM_DEFAULT_CH_B = 3;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] CPM_MAP_A_RESET = 8'h04;
	localparam logic [7:0] CPM_MAP_B_RESET = 8'h08;
	localparam logic [7:0] CPM_OUT_RESET = 8'h00;

	// ---------------------------------------------------------------
	// synchroniser depth for pins and supply monitors
	// ---------------------------------------------------------------
	localparam int CPM_SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		CPM_MODE_SLEEP,
		CPM_MODE_FAILSAFE,
		CPM_MODE_ACTIVE
	} cpm_mode_e;

	typedef struct packed {
		logic [7:0] map_a;
		logic [7:0] map_b;
		logic [7:0] out;
		logic [7:0] drive;
		logic [1:0] mon;
		cpm_mode_e mode;
		logic uv_latched;
		logic spi_allowed;
		logic uv_detect_en;
	} cpm_state_s;

endpackage

// >>> src/cpm_sync.sv
// two flip-flop synchroniser for a group of unrelated level inputs
// assumes each bit is an independent slow level, not a bus
`timescale 1ns/1ns
module cpm_sync
	import cpm_pkg::*;
#(
	parameter int WIDTH = 6
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	if (WIDTH < 1) begin : g_chk
		$error("cpm_sync: WIDTH must be at least one");
	end

	// first stage feeds the second stage only
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

// >>> src/cpm_chan_map.sv
// combines the output register with the mapped direct inputs
// assumes map and output values already reflect any register reset
`timescale 1ns/1ns
module cpm_chan_map
	import cpm_pkg::*;
#(
	parameter int CHANNELS = 8
) (
	// register values
	input wire logic [CHANNELS-1:0] out_bits,
	input wire logic [CHANNELS-1:0] map_a,
	input wire logic [CHANNELS-1:0] map_b,
	// synchronised pin levels
	input wire logic in_a,
	input wire logic in_b,
	// requested channel state
	output logic [CHANNELS-1:0] request
);

	// a channel is asked on by its own bit or by any pin mapped to it
	always_comb begin
		request = out_bits | (map_a & {CHANNELS{in_a}})
			| (map_b & {CHANNELS{in_b}});
	end

endmodule

// >>> src/cpm_core.sv
// control pin and supply mode logic of an eight channel power switch
// assumes supply monitor flags and pins are asynchronous levels and the
// register write strobes come from serial logic on clk_sys
//
// Contract
// R1 - after reset input a drives channel 2, input b channel 3 only
// R2 - software may reprogram each input map to other or more channels
// R3 - channel drive is output bit OR every mapped active input
// R4 - input levels are reported continuously, also in fail-safe
// R5 - standby low with an input high enters fail-safe, default channel on
// R6 - standby low with all inputs low enters sleep
// R7 - host holds standby level for its settle time before changing
// R8 - standby low holds all serial registers at defaults
// R9 - sleep switches off undervoltage detection on both supplies
// R10 - sleep refuses serial transfers and keeps SO released
// R11 - both supplies low blocks power stages, serial access, resets regs
// R12 - logic supply low blocks serial access and resets registers
// R13 - battery low disables channels, re-enabled at operating threshold
// R14 - between thresholds channels stay on but off ones stay off
// R15 - each map holds one select bit per channel, default one bit
`timescale 1ns/1ns
module cpm_core
	import cpm_pkg::*;
#(
	parameter int CHANNELS = CPM_CHANNELS
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// control pins
	input wire logic direct_input_a,
	input wire logic direct_input_b,
	input wire logic standby_pin,
	// supply monitors
	input wire logic logic_uv,
	input wire logic battery_uv,
	input wire logic battery_below_op,
	// register writes from the serial logic
	input wire logic map_a_wr,
	input wire logic [CHANNELS-1:0] map_a_wdata,
	input wire logic map_b_wr,
	input wire logic [CHANNELS-1:0] map_b_wdata,
	input wire logic out_wr,
	input wire logic [CHANNELS-1:0] out_wdata,
	// register contents
	output logic [CHANNELS-1:0] input_a_channel_map,
	output logic [CHANNELS-1:0] input_b_channel_map,
	output logic [CHANNELS-1:0] out_value,
	output logic [1:0] input_level_monitor,
	// channels and status
	output logic [CHANNELS-1:0] channel_drive,
	output logic [1:0] mode,
	output logic spi_allowed,
	output logic uv_detect_enable
);

	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	if (CHANNELS != CPM_CHANNELS) begin : g_chk
		$error("cpm_core: reset maps are laid out for eight channels");
	end

	// ---------------------------------------------------------------
	// pin and monitor synchronisation
	// ---------------------------------------------------------------
	logic [5:0] sync_q;
	logic in_a_s;
	logic in_b_s;
	logic standby_s;
	logic logic_uv_s;
	logic battery_uv_s;
	logic below_op_s;

	cpm_sync #(
		.WIDTH(6)
	) u_sync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.async_in({battery_below_op, battery_uv, logic_uv, standby_pin,
			direct_input_b, direct_input_a}),
		.sync_out(sync_q)
	);

	assign in_a_s = sync_q[0];
	assign in_b_s = sync_q[1];
	assign standby_s = sync_q[2];
	assign logic_uv_s = sync_q[3];
	assign battery_uv_s = sync_q[4];
	assign below_op_s = sync_q[5];

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	cpm_state_s s_reg;
	cpm_state_s s_next;
	logic regs_reset;
	logic any_input;
	logic power_block;
	logic [CHANNELS-1:0] eff_map_a;
	logic [CHANNELS-1:0] eff_map_b;
	logic [CHANNELS-1:0] eff_out;
	logic [CHANNELS-1:0] req;

	assign any_input = in_a_s | in_b_s;
	// R8 standby resets registers
	// R12 logic supply resets registers
	// R11 both supplies low also lands here through logic_uv_s
	assign regs_reset = !standby_s || logic_uv_s;
	// R13 battery low blocks channels
	// R11 power stages blocked
	assign power_block = battery_uv_s || s_reg.uv_latched;

	// registers read as defaults in the very cycle the reset condition
	// appears, so fail-safe uses the default mapping without a lag
	// R5 fail-safe default channel
	// R1 default mapping
	always_comb begin
		eff_map_a = regs_reset ? CPM_MAP_A_RESET : s_reg.map_a;
		eff_map_b = regs_reset ? CPM_MAP_B_RESET : s_reg.map_b;
		eff_out = regs_reset ? CPM_OUT_RESET : s_reg.out;
	end

	// R3 or of register and pins
	cpm_chan_map #(
		.CHANNELS(CHANNELS)
	) u_map (
		.out_bits(eff_out),
		.map_a(eff_map_a),
		.map_b(eff_map_b),
		.in_a(in_a_s),
		.in_b(in_b_s),
		.request(req)
	);

	always_comb begin
		s_next = s_reg;
		// R4 monitor always live
		s_next.mon = {in_b_s, in_a_s};
		// R5 fail-safe entry
		// R6 sleep entry
		if (standby_s) begin
			s_next.mode = CPM_MODE_ACTIVE;
		end else if (any_input) begin
			s_next.mode = CPM_MODE_FAILSAFE;
		end else begin
			s_next.mode = CPM_MODE_SLEEP;
		end
		// R9 detection off in sleep
		s_next.uv_detect_en = standby_s || any_input;
		// R10 no serial in sleep
		// R12 no serial on logic supply low
		s_next.spi_allowed = (standby_s || any_input) && !logic_uv_s;
		// R2 software map writes
		// R15 one select bit per channel
		if (regs_reset) begin
			s_next.map_a = CPM_MAP_A_RESET;
			s_next.map_b = CPM_MAP_B_RESET;
			s_next.out = CPM_OUT_RESET;
		end else begin
			if (map_a_wr) begin
				s_next.map_a = map_a_wdata;
			end
			if (map_b_wr) begin
				s_next.map_b = map_b_wdata;
			end
			if (out_wr) begin
				s_next.out = out_wdata;
			end
		end
		// R13 hold off until operating threshold
		if (battery_uv_s) begin
			s_next.uv_latched = 1'b1;
		end else if (!below_op_s) begin
			s_next.uv_latched = 1'b0;
		end
		// R14 no new turn-on between thresholds
		if (power_block) begin
			s_next.drive = '0;
		end else if (below_op_s) begin
			s_next.drive = req & s_reg.drive;
		end else begin
			s_next.drive = req;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_reg.map_a <= CPM_MAP_A_RESET;
			s_reg.map_b <= CPM_MAP_B_RESET;
			s_reg.out <= CPM_OUT_RESET;
			s_reg.drive <= '0;
			s_reg.mon <= 2'h0;
			s_reg.mode <= CPM_MODE_SLEEP;
			s_reg.uv_latched <= 1'b0;
			s_reg.spi_allowed <= 1'b0;
			s_reg.uv_detect_en <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign input_a_channel_map = s_reg.map_a;
	assign input_b_channel_map = s_reg.map_b;
	assign out_value = s_reg.out;
	assign input_level_monitor = s_reg.mon;
	assign channel_drive = s_reg.drive;
	assign mode = s_reg.mode;
	assign spi_allowed = s_reg.spi_allowed;
	assign uv_detect_enable = s_reg.uv_detect_en;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	a_default_map_a: assert property ( // R1
		!standby_s |=> s_reg.map_a == CPM_MAP_A_RESET
	) else $error("map a not at default while in standby");

	a_map_b_write: assert property ( // R2
		(standby_s && !logic_uv_s && map_b_wr)
		|=> s_reg.map_b == $past(map_b_wdata)
	) else $error("map b write not taken");

	a_drive_or: assert property ( // R3
		(standby_s && !logic_uv_s && !power_block && !below_op_s)
		|=> s_reg.drive == ($past(s_reg.out)
			| ($past(s_reg.map_a) & {CHANNELS{$past(in_a_s)}})
			| ($past(s_reg.map_b) & {CHANNELS{$past(in_b_s)}}))
	) else $error("drive is not the or of register and inputs");

	a_monitor_live: assert property ( // R4
		##1 s_reg.mon == $past({in_b_s, in_a_s})
	) else $error("input monitor does not follow the pins");

	a_failsafe_ch2: assert property ( // R5
		(!standby_s && in_a_s && !power_block && !below_op_s)
		|=> s_reg.drive[CPM_DEFAULT_CH_A]
			&& s_reg.mode == CPM_MODE_FAILSAFE
	) else $error("fail-safe did not drive the default channel");

	a_sleep_quiet: assert property ( // R6
		s_reg.mode == CPM_MODE_SLEEP |-> s_reg.drive == '0
	) else $error("channel on in sleep");

	a_sleep_no_uv: assert property ( // R9
		(!standby_s && !any_input) |=> !s_reg.uv_detect_en
	) else $error("undervoltage detection on in sleep");

	a_sleep_no_spi: assert property ( // R10
		s_reg.mode == CPM_MODE_SLEEP |-> !s_reg.spi_allowed
	) else $error("serial allowed in sleep");

	a_logic_uv_regs: assert property ( // R12
		logic_uv_s |=> !s_reg.spi_allowed && s_reg.out == CPM_OUT_RESET
	) else $error("logic undervoltage did not block serial access");

	a_battery_off: assert property ( // R13
		battery_uv_s |=> s_reg.drive == '0 && s_reg.uv_latched
	) else $error("battery undervoltage left a channel on");

	a_uv_release: assert property ( // R13
		(s_reg.uv_latched && !battery_uv_s && !below_op_s)
		|=> !s_reg.uv_latched
	) else $error("channels not re-enabled at operating threshold");

	a_no_turn_on: assert property ( // R14
		below_op_s |=> (s_reg.drive & ~$past(s_reg.drive)) == '0
	) else $error("channel turned on below operating threshold");

	a_failsafe_ch3: assert property ( // R5
		(!standby_s && in_b_s && !power_block && !below_op_s)
		|=> s_reg.drive[CPM_DEFAULT_CH_B]
			&& s_reg.mode == CPM_MODE_FAILSAFE
	) else $error("fail-safe did not drive the second default channel");

	a_standby_regs: assert property ( // R8
		!standby_s |=> s_reg.out == CPM_OUT_RESET
			&& s_reg.map_b == CPM_MAP_B_RESET
	) else $error("serial registers not at default while in standby");

	a_both_uv: assert property ( // R11
		(logic_uv_s && battery_uv_s) |=> s_reg.drive == '0
			&& !s_reg.spi_allowed && s_reg.map_a == CPM_MAP_A_RESET
	) else $error("both supplies low left a stage or serial access on");

	c_failsafe: cover property (
		s_reg.mode == CPM_MODE_ACTIVE ##1 s_reg.mode == CPM_MODE_FAILSAFE
	);
	c_sleep_wake: cover property (
		s_reg.mode == CPM_MODE_SLEEP ##1 s_reg.mode == CPM_MODE_ACTIVE
	);
	c_uv_cycle: cover property (
		s_reg.uv_latched ##1 !s_reg.uv_latched ##1 s_reg.drive != '0
	);
	c_write_refused: cover property (
		!standby_s && out_wr
	);

endmodule

// >>> sim/cpm_host_model.sv
// host side model: drives both direct inputs and the standby pin
// assumes bench requests change just after a clock edge
`timescale 1ns/1ns
module cpm_host_model #(
	parameter int SETTLE = 4
) (
	// clock
	input wire logic clk_sys,
	// requests from the bench
	input wire logic req_a,
	input wire logic req_b,
	input wire logic req_standby,
	// pins
	output logic direct_input_a = 1'b0,
	output logic direct_input_b = 1'b0,
	output logic standby_pin = 1'b1
);
	int held = SETTLE;

	always @(posedge clk_sys) begin
		direct_input_a <= req_a;
		direct_input_b <= req_b;
		if (req_standby != standby_pin && held >= SETTLE) begin
			standby_pin <= req_standby;
			held <= 0;
		end else begin
			held <= held + 1;
		end
	end
endmodule

// >>> sim/control_pin_mode_logic_tb.sv
// bench for the control pin and supply mode logic
// assumes standby changes after a host settle time, direct inputs at the next edge, and outputs follow in 3 edges
`timescale 1ns/1ns
module control_pin_mode_logic_tb;
	import cpm_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic req_a = 1'b0, req_b = 1'b0, req_sb = 1'b1;
	logic luv = 1'b0, buv = 1'b0, bop = 1'b0;
	logic [2:0] wr = 3'h0;
	logic [7:0] wd = 8'h00;
	logic in_a, in_b, sb, spi, uvd;
	logic [7:0] map_a, map_b, outv, drv;
	logic [1:0] mon, mode;
	int n_errors = 0;
	int tests_run = 0;

	initial begin
		forever #2 clk_sys = ~clk_sys;
	end

	cpm_host_model u_cpm_host_model (.clk_sys(clk_sys), .req_a(req_a),
		.req_b(req_b), .req_standby(req_sb), .direct_input_a(in_a),
		.direct_input_b(in_b), .standby_pin(sb));

	cpm_core u_cpm_core (.clk_sys(clk_sys), .rst_b(rst_b),
		.direct_input_a(in_a), .direct_input_b(in_b), .standby_pin(sb),
		.logic_uv(luv), .battery_uv(buv), .battery_below_op(bop),
		.map_a_wr(wr[0]), .map_a_wdata(wd), .map_b_wr(wr[1]),
		.map_b_wdata(wd), .out_wr(wr[2]), .out_wdata(wd),
		.input_a_channel_map(map_a), .input_b_channel_map(map_b),
		.out_value(outv), .input_level_monitor(mon), .channel_drive(drv),
		.mode(mode), .spi_allowed(spi), .uv_detect_enable(uvd));

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// room for the host settle time plus the synchronisers
	task automatic pins(input logic a, input logic b, input logic s);
		req_a = a;
		req_b = b;
		req_sb = s;
		wait_cyc(12);
	endtask

	task automatic write(input int sel, input logic [7:0] d);
		wr[sel] = 1'b1;
		wd = d;
		wait_cyc(1);
		wr = 3'h0;
		wait_cyc(3);
	endtask

	// packs mode, monitor, serial enable and detector enable
	function automatic logic [7:0] st();
		return {2'h0, mode, mon, spi, uvd};
	endfunction

	task automatic test_done;
		if (n_errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		wait_cyc(6);
		rst_b = 1'b1;
		wait_cyc(6);
		chk(map_a, CPM_MAP_A_RESET); // map defaults
		chk(map_b, CPM_MAP_B_RESET); // map defaults
		chk(outv, CPM_OUT_RESET); // output register default
		chk(st(), 8'h23); // active with detectors on
		pins(1'b1, 1'b0, 1'b1);
		chk(drv, 8'h04); // input a channel
		chk(st(), 8'h27); // level shown
		pins(1'b0, 1'b1, 1'b1);
		chk(drv, 8'h08); // input b channel
		write(0, 8'h81);
		write(1, 8'h48);
		write(2, 8'h10);
		chk(map_a, 8'h81); // map written
		chk(map_b, 8'h48); // map written
		pins(1'b1, 1'b1, 1'b1);
		chk(drv, 8'hd9); // or of sources
		pins(1'b1, 1'b1, 1'b0);
		chk(drv, 8'h0c); // default channels
		chk(st(), 8'h1f); // fail-safe
		chk(map_a, 8'h04); // map back to default
		chk(map_b, CPM_MAP_B_RESET); // map back to default
		write(2, 8'hff);
		chk(outv, 8'h00); // write overridden
		pins(1'b0, 1'b0, 1'b0);
		chk(st(), 8'h00); // sleep
		chk(drv, 8'h00); // all off
		pins(1'b0, 1'b0, 1'b1);
		write(2, 8'h21);
		chk(drv, 8'h21); // output register only
		luv = 1'b1;
		wait_cyc(5);
		chk(outv, 8'h00); // registers reset
		chk(st(), 8'h21); // serial blocked
		write(2, 8'h40);
		chk(outv, 8'h00); // write refused
		buv = 1'b1;
		bop = 1'b1;
		pins(1'b1, 1'b0, 1'b1);
		chk(drv, 8'h00); // stages blocked
		chk(st(), 8'h25); // serial blocked
		luv = 1'b0;
		buv = 1'b0;
		wait_cyc(5);
		chk(drv, 8'h00); // held off below threshold
		bop = 1'b0;
		wait_cyc(5);
		chk(drv, 8'h04); // re-enabled
		bop = 1'b1;
		wait_cyc(5);
		chk(drv, 8'h04); // on channel stays on
		write(2, 8'h01);
		chk(drv, 8'h04); // no new turn-on
		pins(1'b0, 1'b0, 1'b1);
		chk(drv, 8'h00); // input turns off
		bop = 1'b0;
		wait_cyc(5);
		chk(drv, 8'h01); // output bit restored
		test_done();
	end

	initial begin
		#20000;
		n_errors++;
		test_done();
	end
endmodule
